// ===== hdl/ucp_top.sv
// Module: host bus and modem pin logic of a two-channel serial controller
//
// Behaviour
// - Ready input state shows in status bit four
// - Ready input gates transfer only with auto-flow
// - Eight-bit three-state host data bus
// - Bus bit zero is least significant, first serial
// - Powered input state shows in modem status
// - Control bit zero one drives terminal pin low
// - Terminal pin high after clearing bit, reset
// - Per-channel interrupt driven only when bit three set
// - Interrupt asserts for enabled sources only
// - Interrupts high-impedance after reset
// - Read strobe fall drives selected register out
// - Write strobe rise loads selected register
// - Bit three clear: interrupt off, user pin high
`default_nettype none
module ucp_top (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Host bus
   input  wire logic [2:0]              reg_addr,
   input  wire logic                    select_n_a,
   input  wire logic                    select_n_b,
   input  wire logic                    read_strobe_n,
   input  wire logic                    write_strobe_n,
   input  wire logic [7:0]              data_in,
   output logic      [7:0]              data_out,
   output logic                         data_oe_n,
   // Modem pins
   input  wire ucp_pkg::ucp_modem_in_t  modem_a,
   input  wire ucp_pkg::ucp_modem_in_t  modem_b,
   output logic                         terminal_ok_out_n_a,
   output logic                         terminal_ok_out_n_b,
   output logic                         user_out_n_a,
   output logic                         user_out_n_b,
   // Interrupts
   input  wire ucp_pkg::ucp_irq_src_t   src_a,
   input  wire ucp_pkg::ucp_irq_src_t   src_b,
   output logic                         irq_out_a,
   output logic                         irq_out_a_oe_n,
   output logic                         irq_out_b,
   output logic                         irq_out_b_oe_n,
   // Flow control toward the serial path
   output logic                         tx_allow_a,
   output logic                         tx_allow_b
);
   ucp_pkg::ucp_state_t st_ff;
   ucp_pkg::ucp_state_t nxt_st;
   ucp_pkg::ucp_modem_in_t mi [2];
   ucp_pkg::ucp_irq_src_t  si [2];
   logic [1:0] sel;
   logic [1:0] irq;
   logic [1:0] allow;

   assign mi[0] = modem_a;
   assign mi[1] = modem_b;
   assign si[0] = src_a;
   assign si[1] = src_b;
   assign sel = {~select_n_b, ~select_n_a};

   // -----------------------------------------------------------------
   // Status and interrupt decode
   // -----------------------------------------------------------------
   function automatic logic [7:0] msr_val(input ucp_pkg::ucp_chan_t c,
                                          input ucp_pkg::ucp_modem_in_t m);
      logic [7:0] v;
      v = 8'h00;
      // Status reads the asserted sense of the low-active pins
      v[ucp_pkg::MSR_READY_BIT] = ~m.far_ready_in_n;
      v[ucp_pkg::MSR_POWER_BIT] = ~m.set_powered_in_n;
      v[ucp_pkg::MSR_D_READY_BIT] = c.delta[0];
      v[ucp_pkg::MSR_D_POWER_BIT] = c.delta[1];
      return v;
   endfunction

   function automatic logic irq_req(input ucp_pkg::ucp_chan_t c,
                                    input ucp_pkg::ucp_irq_src_t s);
      return (c.irq_enable_reg[ucp_pkg::IER_RX_ERR_BIT] & s.rx_err)
           | (c.irq_enable_reg[ucp_pkg::IER_RX_DATA_BIT] & s.rx_data)
           | (c.irq_enable_reg[ucp_pkg::IER_TX_SPACE_BIT] & s.tx_space)
           | (c.irq_enable_reg[ucp_pkg::IER_MODEM_BIT] & (|c.delta));
   endfunction

   function automatic logic [7:0] reg_read(input ucp_pkg::ucp_chan_t c,
                                           input ucp_pkg::ucp_modem_in_t m,
                                           input logic [2:0] a);
      case (a)
         ucp_pkg::ADDR_IER: reg_read = c.irq_enable_reg;
         ucp_pkg::ADDR_EFR: reg_read = c.enhanced_feature_reg;
         ucp_pkg::ADDR_MCR: reg_read = c.modem_control_reg;
         ucp_pkg::ADDR_MSR: reg_read = msr_val(c, m);
         default:           reg_read = 8'h00;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      logic rd_fall;
      logic rd_rise;
      logic wr_rise;
      logic [1:0] cur;
      rd_fall = 1'b0;
      rd_rise = 1'b0;
      wr_rise = 1'b0;
      cur = 2'b00;
      nxt_st = st_ff;
      rd_fall = st_ff.rd_prev & ~read_strobe_n;
      rd_rise = ~st_ff.rd_prev & read_strobe_n;
      wr_rise = ~st_ff.wr_prev & write_strobe_n;
      nxt_st.rd_prev = read_strobe_n;
      nxt_st.wr_prev = write_strobe_n;
      for (int i = 0; i < 2; i++) begin
         cur = {mi[i].set_powered_in_n, mi[i].far_ready_in_n};
         nxt_st.ch[i].prev_in = cur;
         // Clearing read of status loses no change in the same cycle
         if (st_ff.rd_st == ucp_pkg::UCP_DRIVE && rd_rise && sel[i]
             && reg_addr == ucp_pkg::ADDR_MSR) begin
            nxt_st.ch[i].delta = 2'b00;
         end
         nxt_st.ch[i].delta = nxt_st.ch[i].delta | (cur ^ st_ff.ch[i].prev_in);
         if (wr_rise && sel[i]) begin
            case (reg_addr)
               ucp_pkg::ADDR_IER: nxt_st.ch[i].irq_enable_reg = data_in;
               ucp_pkg::ADDR_EFR: nxt_st.ch[i].enhanced_feature_reg = data_in;
               ucp_pkg::ADDR_MCR: nxt_st.ch[i].modem_control_reg = data_in;
               default: ;
            endcase
         end
      end
      case (st_ff.rd_st)
         ucp_pkg::UCP_IDLE: begin
            if (rd_fall && (|sel)) begin
               nxt_st.rd_st = ucp_pkg::UCP_DRIVE;
               nxt_st.doe_n = 1'b0;
               nxt_st.dout = sel[0] ? reg_read(st_ff.ch[0], mi[0], reg_addr)
                                    : reg_read(st_ff.ch[1], mi[1], reg_addr);
            end
         end
         ucp_pkg::UCP_DRIVE: begin
            // Released at strobe end or when select drops mid-read
            if (read_strobe_n || !(|sel)) begin
               nxt_st.rd_st = ucp_pkg::UCP_HOLD;
               nxt_st.doe_n = 1'b1;
               nxt_st.dout = ucp_pkg::BUS_IDLE;
            end
         end
         ucp_pkg::UCP_HOLD: begin
            nxt_st.rd_st = ucp_pkg::UCP_IDLE;
         end
         default: begin
            nxt_st.rd_st = ucp_pkg::UCP_IDLE;
            nxt_st.doe_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '{ch: '{default: '{irq_enable_reg: ucp_pkg::RST_REG, enhanced_feature_reg: ucp_pkg::RST_REG,
                                      modem_control_reg: ucp_pkg::RST_REG, delta: 2'b00,
                                      prev_in: 2'b11}},
                    rd_st: ucp_pkg::UCP_IDLE, dout: ucp_pkg::BUS_IDLE,
                    doe_n: 1'b1, wr_prev: 1'b1, rd_prev: 1'b1};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -----------------------------------------------------------------
   // Pin outputs
   // -----------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_ch
      assign irq[g] = irq_req(st_ff.ch[g], si[g]);
      // Auto-flow off: ready pin has no effect on transfer
      assign allow[g] = ~st_ff.ch[g].enhanced_feature_reg[ucp_pkg::EFR_AUTO_READY_BIT]
                        | ~mi[g].far_ready_in_n;
   end

   assign data_out = st_ff.dout;
   assign data_oe_n = st_ff.doe_n;
   assign terminal_ok_out_n_a = ~st_ff.ch[0].modem_control_reg[ucp_pkg::MCR_TERM_BIT];
   assign terminal_ok_out_n_b = ~st_ff.ch[1].modem_control_reg[ucp_pkg::MCR_TERM_BIT];
   assign user_out_n_a = ~st_ff.ch[0].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT];
   assign user_out_n_b = ~st_ff.ch[1].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT];
   assign irq_out_a = st_ff.ch[0].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT] & irq[0];
   assign irq_out_b = st_ff.ch[1].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT] & irq[1];
   assign irq_out_a_oe_n = ~st_ff.ch[0].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT];
   assign irq_out_b_oe_n = ~st_ff.ch[1].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT];
   assign tx_allow_a = allow[0];
   assign tx_allow_b = allow[1];

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_rd_start;
      $fell(read_strobe_n) && (|sel) && st_ff.rd_st == ucp_pkg::UCP_IDLE;
   endsequence

   a_read_drives_bus: assert property (@(posedge clk) disable iff (rst)
      s_rd_start |=> !data_oe_n)
      else $error("Bus not driven after read strobe fall");

   a_bus_released: assert property (@(posedge clk) disable iff (rst)
      (st_ff.rd_st == ucp_pkg::UCP_IDLE) |-> data_oe_n)
      else $error("Bus driven while idle");

   a_bus_release_end: assert property (@(posedge clk) disable iff (rst)
      (!data_oe_n && read_strobe_n) |=> data_oe_n)
      else $error("Bus held after read end");

   a_status_ready: assert property (@(posedge clk) disable iff (rst)
      (s_rd_start ##0 (!select_n_a && reg_addr == ucp_pkg::ADDR_MSR))
      |=> data_out[ucp_pkg::MSR_READY_BIT] == !$past(modem_a.far_ready_in_n))
      else $error("Status ready bit wrong");

   a_status_power: assert property (@(posedge clk) disable iff (rst)
      (s_rd_start ##0 (!select_n_a && reg_addr == ucp_pkg::ADDR_MSR))
      |=> data_out[ucp_pkg::MSR_POWER_BIT] == !$past(modem_a.set_powered_in_n))
      else $error("Status powered bit wrong");

   a_term_write: assert property (@(posedge clk) disable iff (rst)
      ($rose(write_strobe_n) && !select_n_a && reg_addr == ucp_pkg::ADDR_MCR
       && data_in[ucp_pkg::MCR_TERM_BIT]) |=> !terminal_ok_out_n_a)
      else $error("Terminal pin not low after write");

   a_term_clear: assert property (@(posedge clk) disable iff (rst)
      ($rose(write_strobe_n) && !select_n_b && reg_addr == ucp_pkg::ADDR_MCR
       && !data_in[ucp_pkg::MCR_TERM_BIT]) |=> terminal_ok_out_n_b)
      else $error("Terminal pin not high after clear");

   a_irq_tristate: assert property (@(posedge clk) disable iff (rst)
      !st_ff.ch[0].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT] |-> (irq_out_a_oe_n && user_out_n_a))
      else $error("Interrupt driven while disabled");

   a_irq_masked: assert property (@(posedge clk) disable iff (rst)
      (st_ff.ch[0].irq_enable_reg == 8'h00) |-> !irq_out_a)
      else $error("Interrupt with no source enabled");

   a_flow_off: assert property (@(posedge clk) disable iff (rst)
      !st_ff.ch[1].enhanced_feature_reg[ucp_pkg::EFR_AUTO_READY_BIT] |-> tx_allow_b)
      else $error("Ready pin gated transfer without auto-flow");

   // -----------------------------------------------------------------
   // Checks: writes, read data and pin states
   // -----------------------------------------------------------------
   sequence s_wr_take_a;
      $rose(write_strobe_n) && !select_n_a;
   endsequence

   a_wr_loads_ier: assert property (@(posedge clk) disable iff (rst)
      (s_wr_take_a ##0 (reg_addr == ucp_pkg::ADDR_IER))
      |=> st_ff.ch[0].irq_enable_reg == $past(data_in))
      else $error("Interrupt enable not loaded by write");

   a_read_mcr: assert property (@(posedge clk) disable iff (rst)
      (s_rd_start ##0 (!select_n_a && reg_addr == ucp_pkg::ADDR_MCR))
      |=> data_out == $past(st_ff.ch[0].modem_control_reg))
      else $error("Read data not the selected control register");

   // A change seen in the clearing cycle must survive, so only quiet pins count
   a_msr_clear: assert property (@(posedge clk) disable iff (rst)
      (st_ff.rd_st == ucp_pkg::UCP_DRIVE && $rose(read_strobe_n) && !select_n_a
       && reg_addr == ucp_pkg::ADDR_MSR && $stable(modem_a))
      |=> st_ff.ch[0].delta == 2'b00)
      else $error("Status change flags kept after status read");

   a_data_idle: assert property (@(posedge clk) disable iff (rst)
      data_oe_n |-> (data_out == ucp_pkg::BUS_IDLE))
      else $error("Data bus value not idle while released");

   a_irq_driven: assert property (@(posedge clk) disable iff (rst)
      st_ff.ch[0].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT] |-> !irq_out_a_oe_n)
      else $error("Interrupt not driven while enabled");

   a_irq_tristate_b: assert property (@(posedge clk) disable iff (rst)
      !st_ff.ch[1].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT] |-> (irq_out_b_oe_n && user_out_n_b))
      else $error("Channel B interrupt driven while disabled");

   a_irq_rx_data: assert property (@(posedge clk) disable iff (rst)
      (st_ff.ch[0].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT] && st_ff.ch[0].irq_enable_reg[ucp_pkg::IER_RX_DATA_BIT]
       && src_a.rx_data) |-> irq_out_a)
      else $error("Interrupt missing for received data");

   a_irq_tx_space: assert property (@(posedge clk) disable iff (rst)
      (st_ff.ch[0].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT] && st_ff.ch[0].irq_enable_reg[ucp_pkg::IER_TX_SPACE_BIT]
       && src_a.tx_space) |-> irq_out_a)
      else $error("Interrupt missing for transmit space");

   a_irq_rx_err: assert property (@(posedge clk) disable iff (rst)
      (st_ff.ch[0].modem_control_reg[ucp_pkg::MCR_IRQ_EN_BIT] && st_ff.ch[0].irq_enable_reg[ucp_pkg::IER_RX_ERR_BIT]
       && src_a.rx_err) |-> irq_out_a)
      else $error("Interrupt missing for receiver error");

   a_flow_gate: assert property (@(posedge clk) disable iff (rst)
      st_ff.ch[0].enhanced_feature_reg[ucp_pkg::EFR_AUTO_READY_BIT]
      |-> (tx_allow_a == !modem_a.far_ready_in_n))
      else $error("Transfer not gated by ready pin under auto-flow");
endmodule
`default_nettype wire

// ===== hdl/ucp_pkg.sv
// Package: constants and carrier types for the channel pin interface
`default_nettype none
package ucp_pkg;
   // Register addresses on the three address inputs
   localparam logic [2:0] ADDR_IER = 3'h1;
   localparam logic [2:0] ADDR_EFR = 3'h2;
   localparam logic [2:0] ADDR_MCR = 3'h4;
   localparam logic [2:0] ADDR_MSR = 3'h6;
   // Field positions
   localparam int MCR_TERM_BIT = 0;
   localparam int MCR_IRQ_EN_BIT = 3;
   localparam int MSR_READY_BIT = 4;
   localparam int MSR_POWER_BIT = 5;
   localparam int MSR_D_READY_BIT = 0;
   localparam int MSR_D_POWER_BIT = 1;
   localparam int EFR_AUTO_READY_BIT = 7;
   localparam int IER_RX_DATA_BIT = 0;
   localparam int IER_TX_SPACE_BIT = 1;
   localparam int IER_RX_ERR_BIT = 2;
   localparam int IER_MODEM_BIT = 3;
   // Values after reset
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] BUS_IDLE = 8'h00;

   // Read strobe sequencing (Gray from IDLE through DRIVE to HOLD; HOLD back to IDLE flips both bits)
   typedef enum logic [1:0] {
      UCP_IDLE  = 2'b00,
      UCP_DRIVE = 2'b01,
      UCP_HOLD  = 2'b11
   } ucp_rd_state_t;

   // Per-channel modem pins
   typedef struct packed {
      logic far_ready_in_n;
      logic set_powered_in_n;
   } ucp_modem_in_t;

   // Per-channel interrupt sources from the rest of the channel
   typedef struct packed {
      logic rx_err;
      logic rx_data;
      logic tx_space;
   } ucp_irq_src_t;

   typedef struct packed {
      logic [7:0] irq_enable_reg;
      logic [7:0] enhanced_feature_reg;
      logic [7:0] modem_control_reg;
      logic [1:0] delta;
      logic [1:0] prev_in;
   } ucp_chan_t;

   typedef struct packed {
      ucp_chan_t [1:0] ch;
      ucp_rd_state_t   rd_st;
      logic [7:0]      dout;
      logic            doe_n;
      logic            wr_prev;
      logic            rd_prev;
   } ucp_state_t;
endpackage
`default_nettype wire

// ===== tb/ucp_modem_model.sv
// Modem partner model: drives the active-low status pins of one channel
`default_nettype none
module ucp_modem_model (
   // Commands from the bench
   input  wire logic             ready,
   input  wire logic             powered,
   // Pins toward the device
   output var ucp_pkg::ucp_modem_in_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   assign pins.far_ready_in_n   = ~ready;
   assign pins.set_powered_in_n = ~powered;
endmodule
`default_nettype wire

// ===== tb/tb_uart_channel_pin_interface.sv
// Testbench: host bus, modem pins and interrupt pins of the channel logic
`default_nettype none
module tb_uart_channel_pin_interface;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, sel_a_n, sel_b_n, rd_n, wr_n, rdy_a, pwr_a;
   logic [2:0] reg_addr;
   logic [7:0] data_in, data_out, d;
   logic data_oe_n, term_a, term_b, user_a, user_b, irq_a, irq_b, oe_a, oe_b, ta, ta_b;
   ucp_pkg::ucp_modem_in_t m_a, m_b;
   ucp_pkg::ucp_irq_src_t  src_a;
   int mismatches = 0;
   int n_checks = 0;
   ucp_modem_model i_mod_a (.ready(rdy_a), .powered(pwr_a), .pins(m_a));
   ucp_modem_model i_mod_b (.ready(1'b0), .powered(1'b0), .pins(m_b));
   ucp_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .select_n_a(sel_a_n),
      .select_n_b(sel_b_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .modem_a(m_a), .modem_b(m_b), .terminal_ok_out_n_a(term_a),
      .terminal_ok_out_n_b(term_b), .user_out_n_a(user_a), .user_out_n_b(user_b),
      .src_a(src_a), .src_b(3'h0), .irq_out_a(irq_a), .irq_out_a_oe_n(oe_a),
      .irq_out_b(irq_b), .irq_out_b_oe_n(oe_b), .tx_allow_a(ta), .tx_allow_b(ta_b));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic chb, input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      data_in <= v;
      sel_a_n <= chb;
      sel_b_n <= ~chb;
      wr_n <= 1'b0;
      @(posedge clk);
      wr_n <= 1'b1;
      repeat (3) @(posedge clk);
      sel_a_n <= 1'b1;
      sel_b_n <= 1'b1;
      #1;
   endtask
   // Holds the strobe well past the answer; one spare edge covers the hold cycle
   task automatic rd(input logic chb, input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      sel_a_n <= chb;
      sel_b_n <= ~chb;
      rd_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("rd_oe_n", 8'h00, {7'h00, data_oe_n});
      v = data_out;
      @(posedge clk);
      rd_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("idle_oe_n", 8'h01, {7'h00, data_oe_n});
      chk("idle_data", 8'h00, data_out);
      @(posedge clk);
      sel_a_n <= 1'b1;
      sel_b_n <= 1'b1;
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_control;
      wr(1'b0, ucp_pkg::ADDR_MCR, 8'h01);
      chk("term_a", 8'h00, {7'h00, term_a});
      chk("term_b", 8'h01, {7'h00, term_b});
      rd(1'b0, ucp_pkg::ADDR_MCR, d);
      chk("mcr_a", 8'h01, d);
      wr(1'b1, ucp_pkg::ADDR_MCR, 8'h08);
      chk("user_b", 8'h00, {7'h00, user_b});
      chk("oe_b", 8'h00, {7'h00, oe_b});
      chk("irq_b", 8'h00, {7'h00, irq_b});
      wr(1'b0, ucp_pkg::ADDR_MCR, 8'h00);
      chk("term_a_off", 8'h01, {7'h00, term_a});
      wr(1'b1, ucp_pkg::ADDR_MCR, 8'h00);
      chk("oe_b_off", 8'h01, {7'h00, oe_b});
      rd(1'b0, 3'h7, d);
      chk("unmapped", 8'h00, d);
   endtask
   task automatic t_status;
      rd(1'b0, ucp_pkg::ADDR_MSR, d);
      rd(1'b0, ucp_pkg::ADDR_MSR, d);
      chk("msr_quiet", 8'h00, d);
      @(posedge clk);
      rdy_a <= 1'b1;
      rd(1'b0, ucp_pkg::ADDR_MSR, d);
      chk("msr_ready", 8'h11, d);
      rd(1'b0, ucp_pkg::ADDR_MSR, d);
      chk("msr_cleared", 8'h10, d);
      @(posedge clk);
      pwr_a <= 1'b1;
      rd(1'b0, ucp_pkg::ADDR_MSR, d);
      chk("msr_power", 8'h32, d);
   endtask
   task automatic t_irq;
      logic [2:0] tbl [3] = '{3'h2, 3'h1, 3'h4};
      wr(1'b0, ucp_pkg::ADDR_MCR, 8'h08);
      for (int i = 0; i < 3; i++) begin
         wr(1'b0, ucp_pkg::ADDR_IER, 8'h01 << i);
         @(posedge clk);
         src_a <= tbl[i];
         settle();
         chk("irq_src", 8'h01, {7'h00, irq_a});
         @(posedge clk);
         src_a <= ~tbl[i];
         settle();
         chk("irq_masked", 8'h00, {7'h00, irq_a});
      end
      wr(1'b0, ucp_pkg::ADDR_IER, 8'h08);
      @(posedge clk);
      src_a <= 3'h0;
      pwr_a <= 1'b0;
      settle();
      chk("irq_modem", 8'h01, {7'h00, irq_a});
      rd(1'b0, ucp_pkg::ADDR_MSR, d);
      chk("msr_drop", 8'h12, d);
      settle();
      chk("irq_acked", 8'h00, {7'h00, irq_a});
      wr(1'b0, ucp_pkg::ADDR_IER, 8'h07);
      @(posedge clk);
      src_a <= 3'h7;
      wr(1'b0, ucp_pkg::ADDR_MCR, 8'h00);
      chk("irq_off", 8'h00, {7'h00, irq_a});
      chk("oe_a_off", 8'h01, {7'h00, oe_a});
      chk("user_a", 8'h01, {7'h00, user_a});
   endtask
   task automatic t_flow;
      @(posedge clk);
      rdy_a <= 1'b0;
      settle();
      chk("flow_off", 8'h01, {7'h00, ta});
      wr(1'b0, ucp_pkg::ADDR_EFR, 8'h80);
      chk("flow_stop", 8'h00, {7'h00, ta});
      chk("flow_b", 8'h01, {7'h00, ta_b});
      @(posedge clk);
      rdy_a <= 1'b1;
      settle();
      chk("flow_go", 8'h01, {7'h00, ta});
   endtask
   // Mid-run reset must return the terminal pin high and float the interrupt again
   task automatic t_reset;
      wr(1'b0, ucp_pkg::ADDR_MCR, 8'h09);
      chk("oe_a_on", 8'h00, {7'h00, oe_a});
      chk("irq_on", 8'h01, {7'h00, irq_a});
      @(posedge clk);
      rst <= 1'b1;
      settle();
      chk("rst2_term", 8'h01, {7'h00, term_a});
      chk("rst2_oe", 8'h01, {7'h00, oe_a});
      chk("rst2_irq", 8'h00, {7'h00, irq_a});
      @(posedge clk);
      rst <= 1'b0;
      rd(1'b0, ucp_pkg::ADDR_MCR, d);
      chk("rst2_mcr", 8'h00, d);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      {rst, sel_a_n, sel_b_n, rd_n, wr_n} = 5'h1F;
      {rdy_a, pwr_a, reg_addr, data_in, src_a} = '0;
      // Time-zero reset edge may race the flops; judge after the first clock
      @(posedge clk);
      #1;
      chk("rst_term", 8'h01, {7'h00, term_a});
      chk("rst_oe", 8'h01, {7'h00, oe_a});
      chk("rst_bus", 8'h01, {7'h00, data_oe_n});
      repeat (9) @(posedge clk);
      rst <= 1'b0;
      t_control();
      t_status();
      t_irq();
      t_flow();
      t_reset();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
endmodule
`default_nettype wire
